// ==== hdl/rxcl_defs.vh ====
// constants of the receive channel configuration latches
`ifndef RXCL_DEFS_VH
`define RXCL_DEFS_VH

`define RXCL_CHANNELS 4
`define RXCL_BANKS_PER_CHANNEL 4'h3
`define RXCL_BANK_RATE_OFS 4'h0
`define RXCL_BANK_LEVEL_OFS 4'h1

`define RXCL_RATE_BIT 1
`define RXCL_TRAIN_BIT 1
`define RXCL_PRI_LSB 4
`define RXCL_SEC_LSB 6

`define RXCL_RATE_BANK_RESET 8'hbf
`define RXCL_LEVEL_BANK_RESET 8'had
`define RXCL_RATE_BANK_CONST 8'h80

`define RXCL_RATE_RESET 1'b1
`define RXCL_PRI_RESET 2'h2
`define RXCL_SEC_RESET 2'h2
`define RXCL_TRAIN_RESET 1'b0

`define RXCL_GAP_MAX 8'hff

`define RXCL_LEVEL_OFF 2'h0
`define RXCL_LEVEL_LOW 2'h1
`define RXCL_LEVEL_MID 2'h2
`define RXCL_LEVEL_HIGH 2'h3

`define RXCL_THRESH_LOW_MV 10'h08c
`define RXCL_THRESH_MID_MV 10'h118
`define RXCL_THRESH_HIGH_MV 10'h1a4

`endif

// ==== hdl/rxcl_clock_out.v ====
// complementary recovered clock output of one channel
`timescale 1ns/10ps
module rxcl_clock_out (
    input wire clk,
    input wire reset,
    input wire ce,
    input wire charTick,
    input wire recvClockRateSel,
    output reg clkTrue,
    output reg clkComp
);

reg halfPhase;
reg next_clkTrue;
reg next_halfPhase;

always @* begin
    next_halfPhase = halfPhase;
    next_clkTrue = clkTrue;
    if (recvClockRateSel) begin
        // one edge per character, receiver alternates between phases
        if (charTick) begin
            next_halfPhase = ~halfPhase;
        end
        next_clkTrue = next_halfPhase;
    end else begin
        // one full period per character; needs ticks at least two cycles apart
        next_clkTrue = charTick;
        next_halfPhase = 1'b0;
    end
end

always @(posedge clk) begin
    if (reset) begin
        halfPhase <= 1'b0;
        clkTrue <= 1'b0;
        clkComp <= 1'b1;
    end else if (ce) begin
        halfPhase <= next_halfPhase;
        clkTrue <= next_clkTrue;
        clkComp <= ~next_clkTrue;
    end
end

endmodule // rxcl_clock_out

// ==== hdl/rxcl_config_latches.v ====
// static configuration latches of four receive channels
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "rxcl_defs.vh"
module rxcl_config_latches (
    input wire clk,
    input wire reset,
    input wire ce,
    input wire configWriteStrobeN,
    input wire [3:0] configAddr,
    input wire [7:0] configData,
    input wire readStrobe,
    input wire [3:0] readAddr,
    output reg [7:0] readData,
    input wire [3:0] charTick,
    input wire [3:0] trainingClockIn,
    input wire [3:0] speedRangeSel,
    output wire [3:0] recoveredClockOutTrue,
    output wire [3:0] recoveredClockOutComp,
    output reg [3:0] recvClockRateSel,
    output reg [7:0] primaryDetectLevel,
    output reg [3:0] primaryDetectEnable,
    output reg [39:0] primaryThresholdMv,
    output reg [7:0] secondaryDetectLevel,
    output reg [3:0] secondaryDetectEnable,
    output reg [39:0] secondaryThresholdMv,
    output reg [3:0] trainingMultSel,
    output reg [3:0] pllTrainingClock,
    output reg [3:0] reservedComboFlag
);

// nominal threshold in millivolts for a level code, zero when off
function [9:0] thresholdOf;
    input [1:0] level;
    begin
        case (level)
            `RXCL_LEVEL_LOW: thresholdOf = `RXCL_THRESH_LOW_MV;
            `RXCL_LEVEL_MID: thresholdOf = `RXCL_THRESH_MID_MV;
            `RXCL_LEVEL_HIGH: thresholdOf = `RXCL_THRESH_HIGH_MV;
            default: thresholdOf = 10'h000;
        endcase
    end
endfunction

// bank address of a channel's bank given its offset within the channel
function [3:0] bankOf;
    input [1:0] channel;
    input [3:0] offset;
    reg [5:0] product;
    begin
        product = {4'h0, channel} * {2'h0, `RXCL_BANKS_PER_CHANNEL};
        bankOf = product[3:0] + offset;
    end
endfunction

// ---------------------------------------------------------------
// write port pins: three stages, accepted once stages two and three agree
// ---------------------------------------------------------------
wire [12:0] pinsRaw;
reg [12:0] pinSync1;
reg [12:0] pinSync2;
reg [12:0] pinSync3;
reg [12:0] pinStable;

assign pinsRaw = {configWriteStrobeN, configAddr, configData};

genvar b;
generate
    for (b = 0; b < 13; b = b + 1) begin : gPinSync
        always @(posedge clk) begin
            if (reset) begin
                pinSync1[b] <= 1'b1;
                pinSync2[b] <= 1'b1;
                pinSync3[b] <= 1'b1;
                pinStable[b] <= 1'b1;
            end else if (ce) begin
                pinSync1[b] <= pinsRaw[b];
                pinSync2[b] <= pinSync1[b];
                pinSync3[b] <= pinSync2[b];
                // a lone glitch on a pin never reaches the latches
                if (pinSync2[b] == pinSync3[b]) begin
                    pinStable[b] <= pinSync3[b];
                end
            end
        end
    end
endgenerate

wire stableStrobeN;
wire [3:0] stableAddr;
wire [7:0] stableData;
wire busSettled;
wire writeActive;

assign stableStrobeN = pinStable[12];
assign stableAddr = pinStable[11:8];
assign stableData = pinStable[7:0];
// address and data must not be moving while the strobe is low
assign busSettled = (pinSync2[11:0] == pinSync3[11:0]) && (pinSync3[11:0] == pinStable[11:0]);
assign writeActive = ~stableStrobeN && busSettled;

// ---------------------------------------------------------------
// per-channel latches and the logic they steer
// ---------------------------------------------------------------
reg [3:0] trainSync1;
reg [3:0] trainSync2;
reg [3:0] trainSync3;
reg [3:0] trainLevel;
reg [3:0] trainLevelPrev;

genvar c;
generate
    for (c = 0; c < `RXCL_CHANNELS; c = c + 1) begin : gChan
        wire rateBankHit;
        wire levelBankHit;
        wire [1:0] chanIndex;

        assign chanIndex = c[1:0];
        assign rateBankHit = writeActive && (stableAddr == bankOf(chanIndex, `RXCL_BANK_RATE_OFS));
        assign levelBankHit = writeActive && (stableAddr == bankOf(chanIndex, `RXCL_BANK_LEVEL_OFS));

        // only the field bits are taken; constant and don't-care positions are dropped
        always @(posedge clk) begin
            if (reset) begin
                recvClockRateSel[c] <= `RXCL_RATE_RESET;
            end else if (ce && rateBankHit) begin
                recvClockRateSel[c] <= stableData[`RXCL_RATE_BIT];
            end
        end

        always @(posedge clk) begin
            if (reset) begin
                primaryDetectLevel[2*c+1:2*c] <= `RXCL_PRI_RESET;
                secondaryDetectLevel[2*c+1:2*c] <= `RXCL_SEC_RESET;
                trainingMultSel[c] <= `RXCL_TRAIN_RESET;
            end else if (ce && levelBankHit) begin
                primaryDetectLevel[2*c+1:2*c] <= stableData[`RXCL_PRI_LSB+1:`RXCL_PRI_LSB];
                secondaryDetectLevel[2*c+1:2*c] <= stableData[`RXCL_SEC_LSB+1:`RXCL_SEC_LSB];
                trainingMultSel[c] <= stableData[`RXCL_TRAIN_BIT];
            end
        end

        // detector controls follow the level latches one cycle later
        always @(posedge clk) begin
            if (reset) begin
                primaryDetectEnable[c] <= 1'b1;
                primaryThresholdMv[10*c+9:10*c] <= `RXCL_THRESH_MID_MV;
                secondaryDetectEnable[c] <= 1'b1;
                secondaryThresholdMv[10*c+9:10*c] <= `RXCL_THRESH_MID_MV;
            end else if (ce) begin
                primaryDetectEnable[c] <= primaryDetectLevel[2*c+1:2*c] != `RXCL_LEVEL_OFF;
                primaryThresholdMv[10*c+9:10*c] <= thresholdOf(primaryDetectLevel[2*c+1:2*c]);
                secondaryDetectEnable[c] <= secondaryDetectLevel[2*c+1:2*c] != `RXCL_LEVEL_OFF;
                secondaryThresholdMv[10*c+9:10*c] <= thresholdOf(secondaryDetectLevel[2*c+1:2*c]);
            end
        end

        // training clock arrives from a pin, so it is filtered like the write port
        always @(posedge clk) begin
            if (reset) begin
                trainSync1[c] <= 1'b0;
                trainSync2[c] <= 1'b0;
                trainSync3[c] <= 1'b0;
                trainLevel[c] <= 1'b0;
                trainLevelPrev[c] <= 1'b0;
            end else if (ce) begin
                trainSync1[c] <= trainingClockIn[c];
                trainSync2[c] <= trainSync1[c];
                trainSync3[c] <= trainSync2[c];
                if (trainSync2[c] == trainSync3[c]) begin
                    trainLevel[c] <= trainSync3[c];
                end
                trainLevelPrev[c] <= trainLevel[c];
            end
        end

        // cycles between filtered training edges, saturating
        wire trainEdge;
        reg [7:0] gapCount;
        reg [7:0] gapLen;

        assign trainEdge = trainLevel[c] != trainLevelPrev[c];

        always @(posedge clk) begin
            if (reset) begin
                gapCount <= 8'h00;
                gapLen <= 8'h00;
            end else if (ce) begin
                if (trainEdge) begin
                    gapCount <= 8'h01;
                    gapLen <= gapCount;
                end else if (gapCount != `RXCL_GAP_MAX) begin
                    gapCount <= gapCount + 8'h01;
                end
            end
        end

        // x2 is one pulse per filtered edge, half a gap long; needs edges two or more cycles apart
        // first pulse after a pause runs long, as the gap is not yet known
        always @(posedge clk) begin
            if (reset) begin
                pllTrainingClock[c] <= 1'b0;
            end else if (ce) begin
                if (trainingMultSel[c]) begin
                    if (trainEdge) begin
                        pllTrainingClock[c] <= 1'b1;
                    end else if (gapCount == {1'b0, gapLen[7:1]}) begin
                        pllTrainingClock[c] <= 1'b0;
                    end
                end else begin
                    pllTrainingClock[c] <= trainLevel[c];
                end
            end
        end

        // the device only reports the reserved setting; it still obeys the latch
        always @(posedge clk) begin
            if (reset) begin
                reservedComboFlag[c] <= 1'b0;
            end else if (ce) begin
                reservedComboFlag[c] <= trainingMultSel[c] && ~speedRangeSel[c];
            end
        end

        rxcl_clock_out uClockOut (
            .clk(clk),
            .reset(reset),
            .ce(ce),
            .charTick(charTick[c]),
            .recvClockRateSel(recvClockRateSel[c]),
            .clkTrue(recoveredClockOutTrue[c]),
            .clkComp(recoveredClockOutComp[c])
        );
    end
endgenerate

// ---------------------------------------------------------------
// readback of the static banks; constants shown, don't-cares read zero
// ---------------------------------------------------------------
reg [7:0] next_readData;
reg readHit;
integer k;

always @* begin
    next_readData = 8'h00;
    readHit = 1'b0;
    for (k = 0; k < `RXCL_CHANNELS; k = k + 1) begin
        if (readAddr == bankOf(k[1:0], `RXCL_BANK_RATE_OFS)) begin
            next_readData = `RXCL_RATE_BANK_CONST;
            next_readData[`RXCL_RATE_BIT] = recvClockRateSel[k];
            readHit = 1'b1;
        end
        if (readAddr == bankOf(k[1:0], `RXCL_BANK_LEVEL_OFS)) begin
            next_readData[`RXCL_SEC_LSB+1:`RXCL_SEC_LSB] = secondaryDetectLevel[2*k+:2];
            next_readData[`RXCL_PRI_LSB+1:`RXCL_PRI_LSB] = primaryDetectLevel[2*k+:2];
            next_readData[`RXCL_TRAIN_BIT] = trainingMultSel[k];
            readHit = 1'b1;
        end
    end
end

// data stand only in the cycle after the strobe
always @(posedge clk) begin
    if (reset) begin
        readData <= 8'h00;
    end else if (ce) begin
        if (readStrobe && readHit) begin
            readData <= next_readData;
        end else begin
            readData <= 8'h00;
        end
    end
end

endmodule // rxcl_config_latches

// ==== sim/rxcl_config_monitor.sv ====
// assertion checker of the configuration latch outputs
`timescale 1ns/10ps
module rxcl_config_monitor (
    input wire clk,
    input wire reset,
    input wire configWriteStrobeN,
    input wire [3:0] charTick,
    input wire [3:0] recoveredClockOutTrue,
    input wire [3:0] recoveredClockOutComp,
    input wire [3:0] recvClockRateSel,
    input wire [7:0] primaryDetectLevel,
    input wire [3:0] primaryDetectEnable,
    input wire [39:0] primaryThresholdMv,
    input wire [7:0] secondaryDetectLevel,
    input wire [39:0] secondaryThresholdMv,
    input wire [3:0] trainingMultSel
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    property p_reset;
        $fell(reset) |-> recvClockRateSel == 4'hf && primaryDetectLevel == 8'haa && trainingMultSel == 4'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("latch values wrong after reset");
    property p_pri_en;
        1 |=> primaryDetectEnable[1] == ($past(primaryDetectLevel[3:2]) != 2'h0);
    endproperty
    a_pri_en: assert property (p_pri_en) else $error("primary detector enable wrong");
    property p_pri_low;
        primaryDetectLevel[3:2] == 2'h1 |=> primaryThresholdMv[19:10] == 10'h08c;
    endproperty
    a_pri_low: assert property (p_pri_low) else $error("primary low threshold wrong");
    property p_sec_high;
        secondaryDetectLevel[3:2] == 2'h3 |=> secondaryThresholdMv[19:10] == 10'h1a4;
    endproperty
    a_sec_high: assert property (p_sec_high) else $error("secondary high threshold wrong");
    property p_half;
        recvClockRateSel[2] && charTick[2] |=> recoveredClockOutTrue[2] != $past(recoveredClockOutTrue[2]);
    endproperty
    a_half: assert property (p_half) else $error("half rate clock did not toggle");
    property p_full;
        !recvClockRateSel[2] && charTick[2] |=> recoveredClockOutTrue[2] ##1 !recoveredClockOutTrue[2];
    endproperty
    a_full: assert property (p_full) else $error("full rate clock pulse wrong");
    property p_comp;
        recoveredClockOutComp == ~recoveredClockOutTrue;
    endproperty
    a_comp: assert property (p_comp) else $error("clock pair not complementary");
    property p_hold;
        configWriteStrobeN [*6] |=> $stable(recvClockRateSel) && $stable(primaryDetectLevel) && $stable(trainingMultSel);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed without a write");
    c_full: cover property (!recvClockRateSel[2] && charTick[2]);
    c_mult: cover property (trainingMultSel[1]);
    c_off: cover property (primaryDetectLevel[3:2] == 2'h0);
endmodule // rxcl_config_monitor
bind rxcl_config_latches rxcl_config_monitor u_mon (.clk, .reset, .configWriteStrobeN, .charTick, .recoveredClockOutTrue,
    .recoveredClockOutComp, .recvClockRateSel, .primaryDetectLevel, .primaryDetectEnable, .primaryThresholdMv,
    .secondaryDetectLevel, .secondaryThresholdMv, .trainingMultSel);

// ==== sim/rxcl_host_model.sv ====
// host model driving the configuration write pins
`timescale 1ns/10ps
module rxcl_host_model (
    input wire clk,
    input wire req,
    input wire [3:0] addr,
    input wire [7:0] data,
    output logic done,
    output logic configWriteStrobeN,
    output logic [3:0] configAddr,
    output logic [7:0] configData
);
    initial begin
        done = 1'b0;
        configWriteStrobeN = 1'b1;
        configAddr = 4'hf;
        configData = 8'hff;
        forever begin
            @(posedge clk);
            if (req) begin
                configAddr <= addr;
                // fixed bits of rate banks are forced, whatever the caller asked
                configData <= (addr % 3 == 0) ? {2'h2, data[5:4], 2'h0, data[1:0]} : data;
                @(posedge clk);
                configWriteStrobeN <= 1'b0;
                repeat (5) @(posedge clk);
                configWriteStrobeN <= 1'b1;
                repeat (5) @(posedge clk);
                // pins stay driven; flipped so a stale load would show
                configData <= ~configData;
                configAddr <= ~configAddr;
                done <= 1'b1;
                @(posedge clk);
                done <= 1'b0;
            end
        end
    end
endmodule // rxcl_host_model

// ==== sim/rxcl_config_latches_tb.sv ====
// self-checking bench of the receive channel configuration latches
`timescale 1ns/10ps
`include "rxcl_defs.vh"
module rxcl_config_latches_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic readStrobe = 1'b0;
    logic [3:0] readAddr = 4'h0;
    logic [3:0] charTick = 4'h0;
    logic [3:0] trainingClockIn = 4'h0;
    logic ce = 1'b1;
    // multiplier only ever set on channel 1, whose speed range is high
    logic [3:0] speedRangeSel = 4'h2;
    logic [3:0] reservedComboFlag;
    logic req = 1'b0;
    logic [3:0] wAddr = 4'h0;
    logic [7:0] wData = 8'h00;
    logic done, configWriteStrobeN;
    logic [3:0] configAddr, recoveredClockOutTrue, recvClockRateSel, primaryDetectEnable;
    logic [3:0] secondaryDetectEnable, trainingMultSel, pllTrainingClock;
    logic [7:0] configData, readData, primaryDetectLevel, secondaryDetectLevel;
    logic [39:0] primaryThresholdMv, secondaryThresholdMv;
    int num_errors = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    rxcl_config_latches DUT (.clk, .reset, .ce, .configWriteStrobeN, .configAddr, .configData,
        .readStrobe, .readAddr, .readData, .charTick, .trainingClockIn, .speedRangeSel,
        .recoveredClockOutTrue, .recoveredClockOutComp(), .recvClockRateSel, .primaryDetectLevel,
        .primaryDetectEnable, .primaryThresholdMv, .secondaryDetectLevel, .secondaryDetectEnable,
        .secondaryThresholdMv, .trainingMultSel, .pllTrainingClock, .reservedComboFlag);
    rxcl_host_model host (.clk, .req, .addr(wAddr), .data(wData), .done, .configWriteStrobeN, .configAddr,
        .configData);
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        int n;
        wAddr <= a;
        wData <= d;
        req <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 40);
        req <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        readStrobe <= 1'b1;
        readAddr <= a;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1 chk("readData", exp, readData);
    endtask
    function automatic logic [9:0] mv(input logic [1:0] code);
        case (code)
            2'h1: return `RXCL_THRESH_LOW_MV;
            2'h2: return `RXCL_THRESH_MID_MV;
            2'h3: return `RXCL_THRESH_HIGH_MV;
            default: return 10'h000;
        endcase
    endfunction
    task automatic t_reset;
        chk("rate", 4'hf, recvClockRateSel);
        chk("levels", 16'haaaa, {primaryDetectLevel, secondaryDetectLevel});
        chk("mult", 4'h0, trainingMultSel);
        chk("thr", {4{10'h118}}, primaryThresholdMv);
        chk("enables", 8'hff, {primaryDetectEnable, secondaryDetectEnable});
        for (int c = 0; c < 4; c++) begin
            rd(4'(3 * c), 8'h82);
            rd(4'(3 * c + 1), 8'ha0);
        end
        rd(4'h2, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_levels;
        logic [1:0] s;
        logic [1:0] p;
        for (int k = 0; k < 4; k++) begin
            s = 2'(k);
            p = 2'(3 - k);
            wr(4'h4, {s, p, 4'hf});
            chk("priLvl", {4'ha, p, 2'h2}, primaryDetectLevel);
            chk("secLvl", {4'ha, s, 2'h2}, secondaryDetectLevel);
            chk("priThr", mv(p), primaryThresholdMv[19:10]);
            chk("secThr", mv(s), secondaryThresholdMv[19:10]);
            chk("enables", {2'h3, p != 2'h0, 3'h7, s != 2'h0, 1'b1}, {primaryDetectEnable, secondaryDetectEnable});
            chk("mult", 4'h2, trainingMultSel);
            rd(4'h4, {s, p, 4'h2});
        end
        $display("test levels done");
    endtask
    task automatic ticks(output int hi);
        hi = 0;
        for (int i = 0; i < 32; i++) begin
            charTick[2] <= (i % 4 == 0);
            @(posedge clk);
            #1 if (recoveredClockOutTrue[2] === 1'b1) hi++;
        end
    endtask
    task automatic t_rate;
        int hi;
        wr(4'h6, 8'h00);
        chk("rate", 4'hb, recvClockRateSel);
        rd(4'h6, 8'h80);
        ticks(hi);
        chk("full high", 8, hi);
        wr(4'h6, 8'h32);
        chk("rate", 4'hf, recvClockRateSel);
        ticks(hi);
        chk("half high", 16, hi);
        $display("test rate done");
    endtask
    task automatic t_train;
        int r0;
        int r1;
        logic [1:0] prev;
        r0 = 0;
        r1 = 0;
        prev = 2'h0;
        for (int i = 0; i < 160; i++) begin
            if (i % 8 == 0) trainingClockIn <= ~trainingClockIn;
            @(posedge clk);
            #1;
            if (pllTrainingClock[0] === 1'b1 && prev[0] === 1'b0) r0++;
            if (pllTrainingClock[1] === 1'b1 && prev[1] === 1'b0) r1++;
            prev = pllTrainingClock[1:0];
        end
        // ten pin rises; one may fall outside the window through the synchroniser
        chk("x1 rises", 1, r0 >= 9 && r0 <= 10);
        chk("x2 rises", 1, r1 >= 19 && r1 <= 21);
        chk("reserved flag", 4'h0, reservedComboFlag);
        $display("test training done");
    endtask
    task automatic t_freeze;
        ce <= 1'b0;
        wr(4'h0, 8'h00);
        ce <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("frozen rate", 4'hf, recvClockRateSel);
        $display("test freeze done");
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_of_test;
    end
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1 t_reset;
        t_levels;
        t_rate;
        t_train;
        t_freeze;
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1 t_reset;
        end_of_test;
    end
endmodule // rxcl_config_latches_tb
